// ===== oag_cfg.svh
// Constants for the operand address generation block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH
`define OAG_WORD_W 16
`define OAG_PHYS_W 20
`define OAG_SEG_SHIFT 4
`define OAG_DISP8_W 8
`define OAG_RESET_WORD 16'h0000
`define OAG_RESET_PHYS 20'h00000
`endif

// ===== oag_pkg.sv
// Types for the operand address generation block.
// Assumes oag_cfg.svh is available by bare name.
`include "oag_cfg.svh"
package oag_pkg;
  // Kind of reference that picks the implicit segment.
  typedef enum logic [1:0] {
    ref_fetch,
    ref_stack,
    ref_string_dst,
    ref_data
  } ref_kind_t;
  // Segment selector, also the override prefix encoding.
  typedef enum logic [1:0] {
    seg_extra,
    seg_code,
    seg_stack,
    seg_data
  } seg_sel_t;
  // Operand addressing mode.
  typedef enum logic [2:0] {
    mode_direct,
    mode_reg_indirect,
    mode_based,
    mode_indexed,
    mode_based_indexed,
    mode_based_indexed_disp,
    mode_register,
    mode_immediate
  } addr_mode_t;
  // Selection of base or index register.
  typedef enum logic [1:0] {
    ptr_src_index,
    ptr_dest_index,
    ptr_general_base,
    ptr_frame_base
  } ptr_sel_t;
endpackage

// ===== oag_offset_adder.sv
// Three-term effective offset adder with optional 8-bit displacement.
// Assumes purely combinational use inside the address generator.
`include "oag_cfg.svh"
module oag_offset_adder #(
  parameter int W = `OAG_WORD_W
) (
  // Terms
  input wire logic [W-1:0] base_val,
  input wire logic [W-1:0] index_val,
  input wire logic [W-1:0] disp_raw,
  // Term enables
  input wire logic use_base,
  input wire logic use_index,
  input wire logic use_disp,
  input wire logic disp_is_byte,
  // Result
  output logic [W-1:0] offset
);
  wire logic [W-1:0] disp_ext;
  wire logic [W-1:0] term_b;
  wire logic [W-1:0] term_i;
  wire logic [W-1:0] term_d;
  assign disp_ext = disp_is_byte ?
      {{(W-`OAG_DISP8_W){disp_raw[`OAG_DISP8_W-1]}}, disp_raw[`OAG_DISP8_W-1:0]} :
      disp_raw;
  assign term_b = use_base ? base_val : '0;
  assign term_i = use_index ? index_val : '0;
  assign term_d = use_disp ? disp_ext : '0;
  // Sum kept at W bits so the carry out of the top bit is lost.
  assign offset = W'(term_b + term_i + term_d);
endmodule

// ===== oag_core.sv
// Operand address generation: segment choice, effective offset, physical address.
// Assumes register values and decoded instruction fields arrive on the core clock.
// Contract
// - Fetches and immediate data reads use the code segment.
// - Stack pushes, pops and frame-base-based references use the stack segment.
// - String destination-index references use extra segment; other data uses data segment.
// - An override prefix replaces the implicit segment for that operand.
// - A memory address is a 16-bit segment base plus a 16-bit offset.
// - Offset is the sum of any of displacement, base and index.
// - Offset adder is 16 bits wide and drops the carry out.
// - An 8-bit displacement is sign extended before it is added.
// - Direct mode offset is the displacement alone.
// - Register indirect offset is source index, dest index, general base or frame base.
// - Based mode adds displacement to general base or frame base.
// - Indexed mode adds displacement to source index or dest index.
// - Based indexed mode adds one base and one index, no displacement.
// - Based indexed with displacement adds base, index and displacement.
// - Register mode reads or writes a general register, 8 or 16 bits, no memory.
// - Immediate mode takes the operand from the instruction bytes.
// - A 32-bit pointer loads both a segment register and an offset.
// - Physical address is segment shifted left four plus offset, 20 bits.
`include "oag_cfg.svh"
module oag_core #(
  parameter int W = `OAG_WORD_W,
  parameter int PW = `OAG_PHYS_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Request
  input wire logic req_valid,
  input wire oag_pkg::addr_mode_t mode,
  input wire oag_pkg::ref_kind_t ref_kind,
  input wire logic override_valid,
  input wire oag_pkg::seg_sel_t override_seg,
  input wire oag_pkg::ptr_sel_t base_sel,
  input wire oag_pkg::ptr_sel_t index_sel,
  input wire logic [W-1:0] disp,
  input wire logic disp_is_byte,
  input wire logic [W-1:0] imm_data,
  // Register operand path
  input wire logic [W-1:0] gen_reg_rd,
  input wire logic reg_is_byte,
  // Address registers
  input wire logic [W-1:0] src_index_reg,
  input wire logic [W-1:0] dest_index_reg,
  input wire logic [W-1:0] general_base_reg,
  input wire logic [W-1:0] frame_base_reg,
  // Segment registers
  input wire logic [W-1:0] code_seg_base,
  input wire logic [W-1:0] stack_seg_base,
  input wire logic [W-1:0] data_seg_base,
  input wire logic [W-1:0] extra_seg_base,
  // Far pointer load
  input wire logic ptr_load,
  input wire logic [2*W-1:0] ptr_value,
  // Results
  output logic res_valid,
  output logic mem_access,
  output oag_pkg::seg_sel_t seg_used,
  output logic [W-1:0] seg_value,
  output logic [W-1:0] eff_offset,
  output logic [PW-1:0] phys_addr,
  output logic [W-1:0] operand_value,
  output logic reg_write_en,
  // Far pointer results
  output logic ptr_seg_we,
  output logic [W-1:0] ptr_seg_value,
  output logic [W-1:0] ptr_offset_value
);
  wire logic is_mem;
  wire logic frame_based;
  wire logic string_dst;
  wire oag_pkg::seg_sel_t implicit_seg;
  wire oag_pkg::seg_sel_t chosen_seg;
  wire logic [W-1:0] base_val;
  wire logic [W-1:0] index_val;
  wire logic [W-1:0] ri_val;
  wire logic [W-1:0] seg_sel_val;
  wire logic [W-1:0] sum_offset;
  wire logic [W-1:0] offset_d;
  wire logic [PW-1:0] phys_d;
  wire logic [W-1:0] reg_operand;
  wire logic [W-1:0] operand_d;
  wire logic use_base;
  wire logic use_index;
  wire logic use_disp;
  logic res_valid_q;
  logic mem_access_q;
  oag_pkg::seg_sel_t seg_used_q;
  logic [W-1:0] seg_value_q;
  logic [W-1:0] eff_offset_q;
  logic [PW-1:0] phys_addr_q;
  logic [W-1:0] operand_q;
  logic reg_write_q;
  logic ptr_we_q;
  logic [W-1:0] ptr_seg_q;
  logic [W-1:0] ptr_off_q;

  // Memory modes are the six below register mode.
  assign is_mem = (mode != oag_pkg::mode_register) && (mode != oag_pkg::mode_immediate);

  // Base picks between the two base registers, index between the two index registers.
  assign base_val = (base_sel == oag_pkg::ptr_frame_base) ? frame_base_reg : general_base_reg;
  assign index_val = (index_sel == oag_pkg::ptr_dest_index) ? dest_index_reg : src_index_reg;
  assign ri_val = (base_sel == oag_pkg::ptr_src_index) ? src_index_reg :
                  (base_sel == oag_pkg::ptr_dest_index) ? dest_index_reg :
                  (base_sel == oag_pkg::ptr_general_base) ? general_base_reg :
                  frame_base_reg;

  // Term usage per mode.
  assign use_base = (mode == oag_pkg::mode_based) ||
                    (mode == oag_pkg::mode_based_indexed) ||
                    (mode == oag_pkg::mode_based_indexed_disp);
  assign use_index = (mode == oag_pkg::mode_indexed) ||
                     (mode == oag_pkg::mode_based_indexed) ||
                     (mode == oag_pkg::mode_based_indexed_disp);
  assign use_disp = (mode == oag_pkg::mode_direct) ||
                    (mode == oag_pkg::mode_based) ||
                    (mode == oag_pkg::mode_indexed) ||
                    (mode == oag_pkg::mode_based_indexed_disp);

  oag_offset_adder #(
    .W(W)
  ) u_adder (
    .base_val(base_val),
    .index_val(index_val),
    .disp_raw(disp),
    .use_base(use_base),
    .use_index(use_index),
    .use_disp(use_disp),
    .disp_is_byte(disp_is_byte),
    .offset(sum_offset)
  );

  assign offset_d = (mode == oag_pkg::mode_reg_indirect) ? ri_val : sum_offset;

  // The frame base as a base element sends the reference to the stack segment.
  assign frame_based = (use_base && (base_sel == oag_pkg::ptr_frame_base)) ||
                       ((mode == oag_pkg::mode_reg_indirect) &&
                        (base_sel == oag_pkg::ptr_frame_base));
  assign string_dst = (ref_kind == oag_pkg::ref_string_dst);
  assign implicit_seg = (ref_kind == oag_pkg::ref_fetch) ? oag_pkg::seg_code :
                        (ref_kind == oag_pkg::ref_stack) ? oag_pkg::seg_stack :
                        frame_based ? oag_pkg::seg_stack :
                        string_dst ? oag_pkg::seg_extra :
                        oag_pkg::seg_data;
  // Fetches always stay in the code segment; a prefix cannot redirect them.
  assign chosen_seg = (override_valid && (ref_kind != oag_pkg::ref_fetch)) ?
                      override_seg : implicit_seg;
  assign seg_sel_val = (chosen_seg == oag_pkg::seg_code) ? code_seg_base :
                       (chosen_seg == oag_pkg::seg_stack) ? stack_seg_base :
                       (chosen_seg == oag_pkg::seg_extra) ? extra_seg_base :
                       data_seg_base;

  // Width cut to PW drops any carry past bit 19.
  assign phys_d = PW'({seg_sel_val, {`OAG_SEG_SHIFT{1'b0}}} + {{(PW-W){1'b0}}, offset_d});

  // Register operands narrow to the low byte when byte sized.
  assign reg_operand = reg_is_byte ? {{(W-8){1'b0}}, gen_reg_rd[7:0]} : gen_reg_rd;
  assign operand_d = (mode == oag_pkg::mode_immediate) ? imm_data : reg_operand;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      res_valid_q <= 1'b0;
      mem_access_q <= 1'b0;
      seg_used_q <= oag_pkg::seg_code;
      seg_value_q <= `OAG_RESET_WORD;
      eff_offset_q <= `OAG_RESET_WORD;
      phys_addr_q <= `OAG_RESET_PHYS;
      operand_q <= `OAG_RESET_WORD;
      reg_write_q <= 1'b0;
    end else begin
      res_valid_q <= req_valid;
      if (req_valid) begin
        mem_access_q <= is_mem;
        seg_used_q <= chosen_seg;
        seg_value_q <= seg_sel_val;
        eff_offset_q <= offset_d;
        phys_addr_q <= phys_d;
        operand_q <= operand_d;
        reg_write_q <= (mode == oag_pkg::mode_register);
      end
    end
  end

  // Far pointer: high word is the segment, low word the offset.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ptr_we_q <= 1'b0;
      ptr_seg_q <= `OAG_RESET_WORD;
      ptr_off_q <= `OAG_RESET_WORD;
    end else begin
      ptr_we_q <= ptr_load;
      if (ptr_load) begin
        ptr_seg_q <= ptr_value[2*W-1:W];
        ptr_off_q <= ptr_value[W-1:0];
      end
    end
  end

  assign res_valid = res_valid_q;
  assign mem_access = mem_access_q;
  assign seg_used = seg_used_q;
  assign seg_value = seg_value_q;
  assign eff_offset = eff_offset_q;
  assign phys_addr = phys_addr_q;
  assign operand_value = operand_q;
  assign reg_write_en = reg_write_q && res_valid_q;
  assign ptr_seg_we = ptr_we_q;
  assign ptr_seg_value = ptr_seg_q;
  assign ptr_offset_value = ptr_off_q;

  // Checks.
  property p_fetch_code;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && ref_kind == oag_pkg::ref_fetch) |=> (seg_used == oag_pkg::seg_code);
  endproperty
  a_fetch_code: assert property (p_fetch_code) else $error("fetch not in code segment");

  property p_frame_stack;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && !override_valid && ref_kind == oag_pkg::ref_data &&
     mode == oag_pkg::mode_based && base_sel == oag_pkg::ptr_frame_base)
    |=> (seg_value == $past(stack_seg_base));
  endproperty
  a_frame_stack: assert property (p_frame_stack) else $error("frame base not stack");

  property p_string_extra;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && !override_valid && ref_kind == oag_pkg::ref_string_dst &&
     mode == oag_pkg::mode_reg_indirect && base_sel == oag_pkg::ptr_dest_index)
    |=> (seg_used == oag_pkg::seg_extra);
  endproperty
  a_string_extra: assert property (p_string_extra) else $error("string dst not extra");

  property p_override;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && override_valid && ref_kind != oag_pkg::ref_fetch)
    |=> (seg_used == $past(override_seg));
  endproperty
  a_override: assert property (p_override) else $error("override ignored");

  property p_direct;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && mode == oag_pkg::mode_direct && !disp_is_byte)
    |=> (eff_offset == $past(disp));
  endproperty
  a_direct: assert property (p_direct) else $error("direct offset wrong");

  property p_bid;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && mode == oag_pkg::mode_based_indexed_disp && disp_is_byte)
    |=> (eff_offset == W'($past(base_val) + $past(index_val) +
         {{(W-8){$past(disp[7])}}, $past(disp[7:0])}));
  endproperty
  a_bid: assert property (p_bid) else $error("based indexed disp offset wrong");

  property p_phys;
    @(posedge clk_sys) disable iff (!arst_n)
    res_valid |-> (phys_addr == PW'({seg_value, 4'h0} + {4'h0, eff_offset}));
  endproperty
  a_phys: assert property (p_phys) else $error("physical address wrong");

  property p_reg_mode;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && mode == oag_pkg::mode_register) |=> (!mem_access && reg_write_en);
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("register mode touched memory");

  property p_imm;
    @(posedge clk_sys) disable iff (!arst_n)
    (req_valid && mode == oag_pkg::mode_immediate) |=> (operand_value == $past(imm_data));
  endproperty
  a_imm: assert property (p_imm) else $error("immediate operand wrong");

  property p_ptr;
    @(posedge clk_sys) disable iff (!arst_n)
    ptr_load |=> (ptr_seg_we && {ptr_seg_value, ptr_offset_value} == $past(ptr_value));
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load wrong");

  c_override: cover property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && override_valid);
  c_wrap: cover property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && is_mem && ({1'b0, seg_sel_val, 4'h0} + {5'h00, offset_d}) > 21'h0fffff);
  c_byte_neg: cover property (@(posedge clk_sys) disable iff (!arst_n)
    req_valid && use_disp && disp_is_byte && disp[7]);
endmodule

// ===== operand_address_generation_tb.sv
// Self-checking bench for oag_core: a reference model predicts every result.
// Assumes oag_pkg is compiled first; the assertions live in the design files.
module operand_address_generation_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, arst_n, req_valid, override_valid, disp_is_byte, reg_is_byte, ptr_load;
  oag_pkg::addr_mode_t mode;
  oag_pkg::ref_kind_t ref_kind;
  oag_pkg::seg_sel_t override_seg, seg_used, e_seg;
  oag_pkg::ptr_sel_t base_sel, index_sel;
  logic [15:0] disp, imm_data, gen_reg_rd, src_index_reg, dest_index_reg, general_base_reg;
  logic [15:0] frame_base_reg, code_seg_base, stack_seg_base, data_seg_base, extra_seg_base;
  logic [31:0] ptr_value;
  logic res_valid, mem_access, reg_write_en, ptr_seg_we;
  logic [15:0] seg_value, eff_offset, operand_value, ptr_seg_value, ptr_offset_value;
  logic [19:0] phys_addr, e_pa;
  logic e_vld, e_mem, e_rwe, e_pwe, e_mchk, e_ochk;
  logic [15:0] e_sv, e_off, e_opv, e_ps, e_po;
  int miscompares = 0;
  int compares = 0;

  oag_core oag_core_i (.clk_sys(clk_sys), .arst_n(arst_n), .req_valid(req_valid), .mode(mode),
    .ref_kind(ref_kind), .override_valid(override_valid), .override_seg(override_seg),
    .base_sel(base_sel), .index_sel(index_sel), .disp(disp), .disp_is_byte(disp_is_byte),
    .imm_data(imm_data), .gen_reg_rd(gen_reg_rd), .reg_is_byte(reg_is_byte),
    .src_index_reg(src_index_reg), .dest_index_reg(dest_index_reg),
    .general_base_reg(general_base_reg), .frame_base_reg(frame_base_reg),
    .code_seg_base(code_seg_base), .stack_seg_base(stack_seg_base),
    .data_seg_base(data_seg_base), .extra_seg_base(extra_seg_base), .ptr_load(ptr_load),
    .ptr_value(ptr_value), .res_valid(res_valid), .mem_access(mem_access),
    .seg_used(seg_used), .seg_value(seg_value), .eff_offset(eff_offset),
    .phys_addr(phys_addr), .operand_value(operand_value), .reg_write_en(reg_write_en),
    .ptr_seg_we(ptr_seg_we), .ptr_seg_value(ptr_seg_value),
    .ptr_offset_value(ptr_offset_value));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic summarize();
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // All-ones and zero are favoured so that the carry drop and the wrap are hit often.
  function automatic logic [15:0] rv();
    case ($urandom % 4)
      0: rv = 16'hffff;
      1: rv = 16'h0000;
      default: rv = 16'($urandom);
    endcase
  endfunction

  function automatic logic [15:0] segv(oag_pkg::seg_sel_t s);
    case (s)
      oag_pkg::seg_extra: segv = extra_seg_base;
      oag_pkg::seg_code: segv = code_seg_base;
      oag_pkg::seg_stack: segv = stack_seg_base;
      default: segv = data_seg_base;
    endcase
  endfunction

  task automatic model();
    int b, x, d, o, p;
    logic fb, bm;
    e_pwe = ptr_load;
    if (ptr_load) begin
      e_ps = ptr_value[31:16];
      e_po = ptr_value[15:0];
    end
    e_vld = req_valid;
    e_rwe = 1'b0;
    if (!req_valid) return;
    case (base_sel)
      oag_pkg::ptr_src_index: b = int'(src_index_reg);
      oag_pkg::ptr_dest_index: b = int'(dest_index_reg);
      oag_pkg::ptr_general_base: b = int'(general_base_reg);
      default: b = int'(frame_base_reg);
    endcase
    x = (index_sel == oag_pkg::ptr_dest_index) ? int'(dest_index_reg) : int'(src_index_reg);
    d = disp_is_byte ? int'($signed(disp[7:0])) : int'(disp);
    case (mode)
      oag_pkg::mode_direct: o = d;
      oag_pkg::mode_reg_indirect: o = b;
      oag_pkg::mode_based: o = b + d;
      oag_pkg::mode_indexed: o = x + d;
      oag_pkg::mode_based_indexed: o = b + x;
      oag_pkg::mode_based_indexed_disp: o = b + x + d;
      default: o = 0;
    endcase
    bm = mode inside {oag_pkg::mode_reg_indirect, oag_pkg::mode_based,
      oag_pkg::mode_based_indexed, oag_pkg::mode_based_indexed_disp};
    fb = bm && base_sel == oag_pkg::ptr_frame_base;
    if (ref_kind == oag_pkg::ref_fetch) e_seg = oag_pkg::seg_code;
    else if (override_valid) e_seg = override_seg;
    else if (ref_kind == oag_pkg::ref_stack || fb) e_seg = oag_pkg::seg_stack;
    else if (ref_kind == oag_pkg::ref_string_dst) e_seg = oag_pkg::seg_extra;
    else e_seg = oag_pkg::seg_data;
    e_mem = !(mode inside {oag_pkg::mode_register, oag_pkg::mode_immediate});
    e_mchk = e_mem;
    e_ochk = !e_mem;
    e_rwe = (mode == oag_pkg::mode_register);
    e_sv = segv(e_seg);
    e_off = o[15:0];
    p = int'(e_sv) * 16 + int'(e_off);
    e_pa = p[19:0];
    e_opv = (mode == oag_pkg::mode_immediate) ? imm_data :
      (reg_is_byte ? {8'h00, gen_reg_rd[7:0]} : gen_reg_rd);
  endtask

  task automatic check_all();
    chk("res_valid", e_vld, res_valid);
    chk("reg_write_en", e_rwe, reg_write_en);
    chk("mem_access", e_mem, mem_access);
    chk("ptr_seg_we", e_pwe, ptr_seg_we);
    chk("ptr_seg_value", e_ps, ptr_seg_value);
    chk("ptr_offset_value", e_po, ptr_offset_value);
    if (e_ochk) chk("operand_value", e_opv, operand_value);
    if (e_mchk) begin
      chk("seg_used", e_seg, seg_used);
      chk("seg_value", e_sv, seg_value);
      chk("eff_offset", e_off, eff_offset);
      chk("phys_addr", e_pa, phys_addr);
    end
  endtask

  task automatic drive();
    req_valid = ($urandom % 4) != 0;
    mode = oag_pkg::addr_mode_t'($urandom_range(0, 7));
    ref_kind = oag_pkg::ref_kind_t'($urandom_range(0, 3));
    override_valid = ($urandom % 3) == 0;
    override_seg = oag_pkg::seg_sel_t'($urandom_range(0, 3));
    base_sel = oag_pkg::ptr_sel_t'($urandom_range(0, 3));
    // Based forms take only the two base registers; indirect takes all four.
    if (mode inside {oag_pkg::mode_based, oag_pkg::mode_based_indexed,
        oag_pkg::mode_based_indexed_disp}) base_sel = oag_pkg::ptr_sel_t'($urandom_range(2, 3));
    index_sel = oag_pkg::ptr_sel_t'($urandom_range(0, 3));
    {disp, imm_data, gen_reg_rd} = {rv(), rv(), rv()};
    {disp_is_byte, reg_is_byte, ptr_load} = 3'($urandom);
    {src_index_reg, dest_index_reg, general_base_reg, frame_base_reg} = {rv(), rv(), rv(), rv()};
    {code_seg_base, stack_seg_base, data_seg_base, extra_seg_base} = {rv(), rv(), rv(), rv()};
    ptr_value = $urandom;
    model();
  endtask

  task automatic do_reset();
    arst_n = 1'b0;
    {req_valid, ptr_load} = 2'b00;
    {e_vld, e_mem, e_rwe, e_pwe, e_mchk, e_ochk} = 6'b000011;
    e_seg = oag_pkg::seg_code;
    {e_sv, e_off, e_opv, e_ps, e_po, e_pa} = '0;
    repeat (4) @(negedge clk_sys);
    check_all();
    arst_n = 1'b1;
  endtask

  initial begin
    arst_n = 1'b0;
    {override_valid, disp_is_byte, reg_is_byte, ptr_value} = '0;
    {mode, ref_kind, override_seg, base_sel, index_sel} = '0;
    {disp, imm_data, gen_reg_rd, src_index_reg, dest_index_reg} = '0;
    {general_base_reg, frame_base_reg, code_seg_base, stack_seg_base} = '0;
    {data_seg_base, extra_seg_base} = '0;
    void'($urandom(32'hb557));
    for (int r = 0; r < 2; r++) begin
      do_reset();
      repeat (1500) begin
        check_all();
        drive();
        @(negedge clk_sys);
      end
    end
    summarize();
  end

  initial begin
    #40000;
    miscompares++;
    summarize();
  end
endmodule
